// ==== dv/board_watchdog_reset_control_test.sv ====
// self-checking bench for the board watchdog and reset combiner
// assumes the design sources under logic/ are compiled first
`timescale 1ns/1ps
`default_nettype none
module board_watchdog_reset_control_test;
   // short base step keeps the 256 s setting within the run
   localparam int unsigned STEP = 4;
   logic core_clk;
   logic rst_n;
   logic wdt_enable;
   logic wdt_service;
   logic [3:0] wdt_timeout_sel;
   logic [1:0] wdt_action;
   logic [5:0] src;
   logic interrupt_line_five;
   logic nmi_out;
   logic board_reset;
   logic wdt_running;
   logic [2:0] outs;
   int fail_count;
   int checks;
   int cycles;
   int seed;
   int n;
   int h;
   int w;
   logic [3:0] sel;
   assign outs = {board_reset, nmi_out, interrupt_line_five};
   board_watchdog_reset_control #(.STEP_CYCLES(STEP)) board_watchdog_reset_control_i (
      .core_clk(core_clk), .rst_n(rst_n), .wdt_enable(wdt_enable),
      .wdt_service(wdt_service), .wdt_timeout_sel(wdt_timeout_sel),
      .wdt_action(wdt_action), .pushbutton_reset(src[0]), .backplane_reset_in(src[1]),
      .supply_low_5v(src[2]), .supply_low_3v3(src[3]), .supply_low_1v8(src[4]),
      .core_regulator_fail(src[5]), .interrupt_line_five(interrupt_line_five),
      .nmi_out(nmi_out), .board_reset(board_reset), .wdt_running(wdt_running));
   ////////////////////////////////////////////////////////////////////////////////
   // clock and a cycle ceiling well above the longest expected run
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 60000) begin
         fail_count++;
         stop_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // cycles from the negedge that sets wdt_enable until an expiry output is seen; selects above 11 clamp
   function automatic int unsigned expiry(input logic [3:0] s);
      return 2 + (STEP << ((s > 4'hb) ? 11 : s));
   endfunction
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         $display("[ERR] %s expected %0h seen %0h", what, exp, got);
         fail_count++;
      end
   endtask
   task automatic arm(input logic [3:0] s, input logic [1:0] a);
      @(negedge core_clk);
      wdt_enable = 1'b1;
      wdt_timeout_sel = s;
      wdt_action = a;
      @(negedge core_clk);
      wdt_enable = 1'b0;
      wdt_timeout_sel = 4'($random(seed));
      wdt_action = 2'($random(seed));
   endtask
   // waits for one expiry output; a count within one cycle of the figure passes
   task automatic expect_out(input int which, input int unsigned ex);
      n = 0;
      while (outs[which] !== 1'b1 && n < 10000) begin
         @(negedge core_clk);
         n++;
      end
      check("expiry delay", ex, (n >= ex - 1 && n <= ex + 1) ? ex : n);
   endtask
   task automatic pulse(input int i, input int len);
      @(negedge core_clk);
      src[i] = 1'b1;
      repeat (2) @(negedge core_clk);
      check("board_reset on source", 1, board_reset);
      check("watchdog cleared", 0, wdt_running);
      repeat (len) @(negedge core_clk);
      src[i] = 1'b0;
      repeat (2) @(negedge core_clk);
      check("board_reset released", 0, board_reset);
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      seed = 32'hb16e;
      rst_n = 1'b0;
      {wdt_enable, wdt_service, wdt_timeout_sel, wdt_action, src} = '0;
      repeat (2) @(negedge core_clk);
      rst_n = 1'b1;
      check("outputs after reset", 0, outs);
      // every reset source, each with the watchdog armed beforehand
      for (int i = 0; i < 6; i++) begin
         arm(4'h3, 2'h0);
         check("armed", 1, wdt_running);
         pulse(i, 1 + ($random(seed) & 3));
      end
      $display("test reset sources done");
      // every action code, random short timeout
      for (int a = 0; a < 4; a++) begin
         sel = 4'($random(seed) & 3);
         arm(sel, 2'(a));
         w = (a > 1) ? 2 : a;
         expect_out(w, expiry(sel) - 1);
         if (w < 2) begin
            check("other outputs quiet", 0, outs & ~(3'h1 << w));
            @(negedge core_clk);
            wdt_service = 1'b1;
            @(negedge core_clk);
            wdt_service = 1'b0;
            check("service clears", 0, outs[w]);
            pulse($random(seed) & 3, 1);
         end else begin
            h = 0;
            while (board_reset === 1'b1 && h < 40) begin
               h++;
               @(negedge core_clk);
            end
            check("reset hold", 32'(wdog_pkg::RESET_HOLD_CYCLES), h);
            check("watchdog off after reset", 0, wdt_running);
         end
      end
      $display("test actions done");
      // re-enable ignored, service restarts the full count, no disable
      arm(4'h2, 2'h0);
      repeat (10) @(negedge core_clk);
      arm(4'h0, 2'h2);
      wdt_service = 1'b1;
      @(negedge core_clk);
      wdt_service = 1'b0;
      check("still running", 1, wdt_running);
      expect_out(0, expiry(4'h2) - 1);
      check("no reset from ignored enable", 0, board_reset);
      pulse(1, 2);
      $display("test service done");
      // top setting and a clamped select
      arm(4'hf, 2'h1);
      expect_out(1, expiry(4'hb) - 1);
      pulse(5, 1);
      $display("test longest timeout done");
      stop_test();
   end
endmodule
`default_nettype wire

// ==== logic/board_watchdog_reset_control.sv ====
// board watchdog with selectable timeout and action, plus the board reset combiner
// assumes all inputs synchronous to core_clk; control inputs come from local decode
`timescale 1ns/1ps
`default_nettype none
module board_watchdog_reset_control #(
   parameter int unsigned STEP_CYCLES = wdog_pkg::BASE_STEP_CYCLES
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // watchdog control from software decode, one-cycle strobes and levels
   input wire logic wdt_enable,
   input wire logic wdt_service,
   input wire logic [3:0] wdt_timeout_sel,
   input wire logic [1:0] wdt_action,
   // reset sources, active high
   input wire logic pushbutton_reset,
   input wire logic backplane_reset_in,
   input wire logic supply_low_5v,
   input wire logic supply_low_3v3,
   input wire logic supply_low_1v8,
   input wire logic core_regulator_fail,
   // outputs
   output logic interrupt_line_five,
   output logic nmi_out,
   output logic board_reset,
   output logic wdt_running
);
   tick_if tk ();

   wdog_prescaler #(.STEP_CYCLES(STEP_CYCLES)) wdog_prescaler_i (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .tk(tk)
   );

   // timeout length in base steps for a setting, clamped to the longest
   function automatic logic [wdog_pkg::TICK_W-1:0] steps_for(input logic [3:0] sel);
      logic [3:0] s;
      s = (sel > wdog_pkg::SEL_MAX) ? wdog_pkg::SEL_MAX : sel;
      steps_for = 12'h001 << s;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // watchdog state
   wdog_pkg::wd_state_type state;
   wdog_pkg::wd_state_type next_state;
   logic [wdog_pkg::TICK_W-1:0] ticks;
   logic [wdog_pkg::TICK_W-1:0] next_ticks;
   logic [wdog_pkg::TICK_W-1:0] limit;
   logic [wdog_pkg::TICK_W-1:0] next_limit;
   logic [1:0] action;
   logic [1:0] next_action;
   logic next_irq;
   logic next_nmi;
   logic expire;
   logic local_rst;

   // the watchdog lives under the board reset it can cause
   assign local_rst = !rst_n || board_reset;
   assign expire = (state == wdog_pkg::WD_RUN) && tk.tick && (ticks == limit - 12'h001);
   assign tk.restart = wdt_service || (wdt_enable && state == wdog_pkg::WD_OFF);

   // settings are latched at enable so a stray write cannot shorten a running watchdog
   always_comb begin
      next_state = state;
      next_ticks = ticks;
      next_limit = limit;
      next_action = action;
      next_irq = interrupt_line_five;
      next_nmi = nmi_out;
      case (state)
         wdog_pkg::WD_OFF: begin
            if (wdt_enable) begin
               next_state = wdog_pkg::WD_RUN;
               next_ticks = wdog_pkg::TICK_RESET;
               next_limit = steps_for(wdt_timeout_sel);
               next_action = wdt_action;
            end
         end
         wdog_pkg::WD_RUN: begin
            // no input leads back to off: only local_rst does
            if (wdt_service) begin
               // a same-cycle expiry still raises its line, as it does for the reset action
               next_ticks = wdog_pkg::TICK_RESET;
               next_irq = expire && (action == wdog_pkg::ACT_IRQ);
               next_nmi = expire && (action == wdog_pkg::ACT_NMI);
            end else if (expire) begin
               next_ticks = wdog_pkg::TICK_RESET;
               // interrupts stay up until serviced, so an expiry is never missed
               next_irq = interrupt_line_five || (action == wdog_pkg::ACT_IRQ);
               next_nmi = nmi_out || (action == wdog_pkg::ACT_NMI);
            end else if (tk.tick) begin
               next_ticks = ticks + 12'h001;
            end
         end
         default: begin
            next_state = wdog_pkg::WD_OFF;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (local_rst) begin
         state <= wdog_pkg::WD_OFF;
         ticks <= wdog_pkg::TICK_RESET;
         limit <= wdog_pkg::TICK_RESET;
         action <= wdog_pkg::ACT_IRQ;
         interrupt_line_five <= 1'b0;
         nmi_out <= 1'b0;
         wdt_running <= 1'b0;
      end else begin
         state <= next_state;
         ticks <= next_ticks;
         limit <= next_limit;
         action <= next_action;
         interrupt_line_five <= next_irq;
         nmi_out <= next_nmi;
         wdt_running <= (next_state == wdog_pkg::WD_RUN);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // reset combiner; a watchdog reset is stretched because it clears its own cause
   logic [4:0] hold;
   logic [4:0] next_hold;
   logic wd_reset_req;
   logic any_source;
   logic next_board_reset;

   assign wd_reset_req = expire && (action != wdog_pkg::ACT_IRQ)
      && (action != wdog_pkg::ACT_NMI);
   assign any_source = pushbutton_reset
      || backplane_reset_in
      || supply_low_5v || supply_low_3v3 || supply_low_1v8 || core_regulator_fail;

   always_comb begin
      next_hold = (hold != 5'h00) ? hold - 5'h01 : 5'h00;
      if (wd_reset_req) begin
         next_hold = wdog_pkg::RESET_HOLD_CYCLES;
      end
      next_board_reset = any_source || wd_reset_req || (next_hold != 5'h00);
   end

   // hold counter survives board reset, only power-on reset clears it
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         hold <= 5'h00;
         board_reset <= 1'b0;
      end else begin
         hold <= next_hold;
         board_reset <= next_board_reset;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   a_button_resets: assert property (@(posedge core_clk) disable iff (!rst_n)
      pushbutton_reset |=> board_reset)
      else $error("pushbutton did not assert board reset");
   a_backplane_resets: assert property (@(posedge core_clk) disable iff (!rst_n)
      backplane_reset_in |=> board_reset)
      else $error("backplane reset input did not assert board reset");
   a_supply_fail_resets: assert property (@(posedge core_clk) disable iff (!rst_n)
      (supply_low_5v || supply_low_3v3 || supply_low_1v8 || core_regulator_fail)
      |=> board_reset)
      else $error("supply or regulator failure did not assert board reset");
   a_no_stop_running: assert property (@(posedge core_clk) disable iff (!rst_n)
      (wdt_running && !board_reset) |=> wdt_running)
      else $error("running watchdog stopped without board reset");
   a_reset_clears_wdt: assert property (@(posedge core_clk) disable iff (!rst_n)
      board_reset |=> !wdt_running && !interrupt_line_five && !nmi_out)
      else $error("board reset did not clear the watchdog");
   a_expire_resets: assert property (@(posedge core_clk) disable iff (!rst_n)
      (expire && action == wdog_pkg::ACT_RESET) |=> board_reset[*8])
      else $error("reset action did not hold board reset");
   a_expire_interrupt_line_five: assert property (@(posedge core_clk) disable iff (local_rst)
      (expire && action == wdog_pkg::ACT_IRQ && !wdt_service) |=> interrupt_line_five && !nmi_out)
      else $error("interrupt action did not raise interrupt line five");
   a_expire_nmi: assert property (@(posedge core_clk) disable iff (local_rst)
      (expire && action == wdog_pkg::ACT_NMI && !wdt_service) |=> nmi_out && !interrupt_line_five)
      else $error("nmi action did not raise nmi");
   a_timeout_range: assert property (@(posedge core_clk) disable iff (!rst_n)
      wdt_running |-> (limit != 12'h000) && (limit <= 12'h800) && $onehot(limit))
      else $error("timeout outside the twelve settings");
   a_service_restarts: assert property (@(posedge core_clk) disable iff (local_rst)
      (wdt_running && wdt_service) |=> ticks == wdog_pkg::TICK_RESET && !expire)
      else $error("service did not restart the timeout");
   // settings frozen and interrupt levels sticky while the watchdog runs
   a_enable_ignored: assert property (@(posedge core_clk) disable iff (local_rst)
      (wdt_running && wdt_enable) |=> $stable(limit) && $stable(action) && wdt_running)
      else $error("enable while running changed the watchdog settings");
   a_irq_sticky: assert property (@(posedge core_clk) disable iff (local_rst)
      (interrupt_line_five && !wdt_service) |=> interrupt_line_five)
      else $error("interrupt line five dropped without service");
   a_nmi_sticky: assert property (@(posedge core_clk) disable iff (local_rst)
      (nmi_out && !wdt_service) |=> nmi_out)
      else $error("nmi dropped without service");
   a_release_follows: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!any_source && !wd_reset_req && hold == 5'h00) |=> !board_reset)
      else $error("board reset held with no source active");

   c_wdt_reset: cover property (@(posedge core_clk) disable iff (!rst_n)
      wd_reset_req ##1 board_reset);
   c_wdt_irq: cover property (@(posedge core_clk) disable iff (!rst_n)
      $rose(interrupt_line_five));
   c_wdt_nmi: cover property (@(posedge core_clk) disable iff (!rst_n)
      $rose(nmi_out));
   c_service: cover property (@(posedge core_clk) disable iff (!rst_n)
      wdt_running && wdt_service ##1 wdt_running);
   c_button: cover property (@(posedge core_clk) disable iff (!rst_n)
      pushbutton_reset ##1 board_reset);
endmodule
`default_nettype wire

// ==== logic/tick_if.sv ====
// carries the base-step tick between the watchdog and its prescaler
// assumes both ends run on the same core clock
`timescale 1ns/1ps
`default_nettype none
interface tick_if;
   logic restart;
   logic tick;
   modport source (input restart, output tick);
   modport sink (output restart, input tick);
endinterface
`default_nettype wire

// ==== logic/wdog_pkg.sv ====
// constants shared by the watchdog, its prescaler and the reset combiner
// assumes one 25 MHz core clock and a synchronous active-low power-on reset
`default_nettype none
package wdog_pkg;
   // core clock period and the base watchdog step, both in nanoseconds
   localparam int unsigned CLK_PERIOD_NS = 40;
   localparam int unsigned BASE_STEP_NS = 125_000_000;
   // base step in clock cycles, rounded down as a longest wait
   localparam int unsigned BASE_STEP_CYCLES = BASE_STEP_NS / CLK_PERIOD_NS;
   // number of timeout settings and the widths they need
   localparam int unsigned TIMEOUT_STEPS = 12;
   localparam logic [3:0] SEL_MAX = 4'hb;
   localparam int unsigned TICK_W = 12;
   // expiry action encodings; the unused code behaves as reset
   localparam logic [1:0] ACT_IRQ = 2'h0;
   localparam logic [1:0] ACT_NMI = 2'h1;
   localparam logic [1:0] ACT_RESET = 2'h2;
   // least width of a watchdog-caused board reset pulse, in clock cycles
   localparam logic [4:0] RESET_HOLD_CYCLES = 5'h10;
   // values after reset
   localparam logic [TICK_W-1:0] TICK_RESET = 12'h000;
   localparam logic [31:0] PRESCALE_RESET = 32'h0000_0000;
   typedef enum logic {WD_OFF, WD_RUN} wd_state_type;
endpackage
`default_nettype wire

// ==== logic/wdog_prescaler.sv ====
// divides the core clock down to one tick per 125 ms base step
// assumes restart is a one-cycle request from the watchdog
`timescale 1ns/1ps
`default_nettype none
module wdog_prescaler #(
   parameter int unsigned STEP_CYCLES = wdog_pkg::BASE_STEP_CYCLES
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // tick towards the watchdog
   tick_if.source tk
);
   localparam logic [31:0] LAST = 32'(STEP_CYCLES - 1);

   logic [31:0] count;
   logic [31:0] next_count;
   logic tick;
   logic next_tick;

   ////////////////////////////////////////////////////////////////////////////
   // restart reloads so that a service always buys a full step
   always_comb begin
      next_count = count + 32'h0000_0001;
      next_tick = 1'b0;
      if (tk.restart) begin
         next_count = wdog_pkg::PRESCALE_RESET;
      end else if (count == LAST) begin
         next_count = wdog_pkg::PRESCALE_RESET;
         next_tick = 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         count <= wdog_pkg::PRESCALE_RESET;
         tick <= 1'b0;
      end else begin
         count <= next_count;
         tick <= next_tick;
      end
   end

   assign tk.tick = tick;
endmodule
`default_nettype wire
